// ===== hdl/fcw_pkg.sv
// Behaviour
// - standard profile applies word bits directly
// - profiles 2 and 3 run a state machine
// - basic profile follows option-board bit layout
// - precharge bit low opens breaker or aborts
// - precharge starts if enabled and fieldbus place
// - other places precharge from ordinary start command, except in basic profile
// - start only on rising edge of run
// - run bit low requests stop
// - fault acknowledge only on rising edge
// - virtual inputs drive relay or parameter force
// - control place 0 pc 1 io 2 keypad 3 fieldbus
// - keypad start held 3 s takes place, copies state
package fcw_pkg;

  // control word layout
  localparam int CW_W = 16;
  localparam int BIT_PRECHARGE = 0;
  localparam int BIT_RUN = 3;
  localparam int BIT_FAULT_ACK = 7;
  localparam int BIT_FB_CONTROL = 10;
  localparam int STD_VIN_LO = 11;
  localparam int STD_VIN_N = 4;
  localparam int GEN_VIN_LO = 12;
  localparam int GEN_VIN_N = 3;
  localparam int BAS_BIT_RUN = 0;
  localparam int BAS_BIT_FAULT = 2;
  localparam int BAS_VIN_LO = 3;
  localparam int VIN_N = 5;
  localparam logic [CW_W-1:0] CW_RST = 16'h0000;

  // width of the reference copied into the keypad
  localparam int REF_W = 16;
  // width of a parameter identifier
  localparam int ID_W = 16;
  localparam int SEL_W = 3;

  // keypad hold time
  localparam longint CLK_HZ = 250_000_000;
  localparam longint KP_HOLD_MS = 3000;
  localparam longint KP_HOLD_CYC = (KP_HOLD_MS * CLK_HZ) / 1000;
  localparam int HOLD_W = 30;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 30'h00000001;

  // profile selector values
  typedef enum logic [1:0] {
    FCW_PROF_BASIC = 2'h0,
    FCW_PROF_STANDARD = 2'h1,
    FCW_PROF_SM_A = 2'h2,
    FCW_PROF_SM_B = 2'h3
  } fcw_prof_e;

  // active control place
  typedef enum logic [1:0] {
    FCW_PLACE_PC = 2'h0,
    FCW_PLACE_IO = 2'h1,
    FCW_PLACE_KEYPAD = 2'h2,
    FCW_PLACE_FIELDBUS = 2'h3
  } fcw_place_e;
  localparam fcw_place_e PLACE_RST = FCW_PLACE_FIELDBUS;

  // drive-profile sequencer states
  typedef enum {
    FCW_SM_LOCKED,
    FCW_SM_READY,
    FCW_SM_RUNNING
  } fcw_sm_e;

  // outputs toward the drive sequencing logic
  typedef struct packed {
    logic run;
    logic start;
    logic fault_ack;
    logic breaker_open;
    logic precharge_abort;
    logic precharge_start;
    logic [VIN_N-1:0] vin;
    logic relay_output;
    logic force_active;
  } fcw_out_s;

  // keypad copy of run state
  typedef struct packed {
    logic copy;
    logic run;
    logic dir;
    logic [REF_W-1:0] ref_val;
  } fcw_kp_s;

  // whole state of the decoder
  typedef struct packed {
    logic [CW_W-1:0] cw;
    logic run_prev;
    logic fault_prev;
    fcw_place_e place;
    logic [31:0] sm;
    logic btn_s1;
    logic btn_s2;
    logic brk_s1;
    logic brk_s2;
    logic [HOLD_W-1:0] hold_cnt;
    logic hold_done;
    logic [ID_W-1:0] force_id; // parameter identifier to force
    fcw_out_s out;
    fcw_kp_s kp;
  } fcw_state_s;

endpackage

// ===== hdl/fcw_decoder.sv
`timescale 1ns/1ps
module fcw_decoder import fcw_pkg::*; #(
  parameter longint KP_HOLD_CYCLES = KP_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // control word from the fieldbus master
  input wire logic [CW_W-1:0] cw_i,
  input wire logic cw_valid_i,
  // configuration parameters
  input wire logic [1:0] profile_sel_i,
  input wire logic place_wr_i,
  input wire logic [1:0] place_i,
  input wire logic precharge_en_i,
  input wire logic [SEL_W-1:0] relay_src_sel_i,
  input wire logic [SEL_W-1:0] force_src_sel_i,
  input wire logic [ID_W-1:0] force_id_i,
  // drive state
  input wire logic drive_start_cmd_i,
  input wire logic dir_i,
  input wire logic [REF_W-1:0] ref_i,
  // pins
  input wire logic breaker_closed_i,
  input wire logic kp_start_btn_i,
  // decoded commands
  output logic run_o,
  output logic start_o,
  output logic fault_ack_o,
  output logic breaker_open_o,
  output logic precharge_abort_o,
  output logic precharge_start_o,
  output logic [VIN_N-1:0] virtual_input_o,
  output logic relay_output_o,
  output logic force_active_o,
  output logic [ID_W-1:0] force_id_o,
  output logic [1:0] place_o,
  output logic kp_copy_o,
  output logic kp_run_o,
  output logic kp_dir_o,
  output logic [REF_W-1:0] kp_ref_o
);

  // refuse hold counts the counter cannot reach, at elaboration
  if (KP_HOLD_CYCLES < 1 || KP_HOLD_CYCLES >= (64'h1 << HOLD_W)) begin
    $error("KP_HOLD_CYCLES out of range");
  end

  localparam logic [HOLD_W-1:0] HOLD_LAST =
    HOLD_W'(KP_HOLD_CYCLES - 1);

  // pick one virtual input by selector, zero when out of range
  function automatic logic vin_pick(input logic [VIN_N-1:0] v,
                                    input logic [SEL_W-1:0] s);
    vin_pick = 1'b0;
    for (int i = 0; i < VIN_N; i++) begin
      if (s == SEL_W'(i)) begin
        vin_pick = v[i];
      end
    end
  endfunction

  fcw_state_s st_reg; // registered state
  fcw_state_s st_next; // next state
  logic run_bit; // run request of the active layout
  logic fault_bit; // fault acknowledge bit of the active layout
  logic run_rise; // rising edge on run request
  logic fb_place; // fieldbus is the active control place
  logic [VIN_N-1:0] vin_w; // virtual inputs of the active layout
  fcw_sm_e sm_cur; // sequencer state as enum
  fcw_sm_e sm_nxt; // sequencer next state

  assign sm_cur = fcw_sm_e'(st_reg.sm);

  // next-state logic
  always_comb begin
    st_next = st_reg;
    sm_nxt = sm_cur;
    run_bit = 1'b0;
    fault_bit = 1'b0;
    vin_w = '0;
    // latch every word written by the master
    if (cw_valid_i) begin
      st_next.cw = cw_i;
    end
    fb_place = (st_reg.place == FCW_PLACE_FIELDBUS);
    // bit layout per profile
    case (fcw_prof_e'(profile_sel_i))
      FCW_PROF_BASIC: begin
        run_bit = st_reg.cw[BAS_BIT_RUN];
        fault_bit = st_reg.cw[BAS_BIT_FAULT];
        vin_w = st_reg.cw[BAS_VIN_LO +: VIN_N];
      end
      FCW_PROF_STANDARD: begin
        // bits 1,2,4-6,8-10,15 are never read here
        run_bit = st_reg.cw[BIT_RUN];
        fault_bit = st_reg.cw[BIT_FAULT_ACK];
        vin_w[STD_VIN_N-1:0] = st_reg.cw[STD_VIN_LO +: STD_VIN_N];
      end
      default: begin
        run_bit = st_reg.cw[BIT_RUN];
        fault_bit = st_reg.cw[BIT_FAULT_ACK];
        vin_w[GEN_VIN_N:1] = st_reg.cw[GEN_VIN_LO +: GEN_VIN_N];
      end
    endcase
    st_next.run_prev = run_bit;
    st_next.fault_prev = fault_bit;
    run_rise = run_bit & ~st_reg.run_prev;
    // fault acknowledge pulse on positive edge only
    st_next.out.fault_ack = fault_bit & ~st_reg.fault_prev;
    // run and start
    st_next.out.start = 1'b0;
    if (profile_sel_i == FCW_PROF_SM_A || profile_sel_i == FCW_PROF_SM_B) begin
      // drive-profile sequencer in application logic
      case (sm_cur)
        FCW_SM_LOCKED: begin
          if (st_reg.cw[BIT_FB_CONTROL] && fb_place) begin
            sm_nxt = FCW_SM_READY;
          end
        end
        FCW_SM_READY: begin
          if (!st_reg.cw[BIT_FB_CONTROL] || !fb_place) begin
            sm_nxt = FCW_SM_LOCKED;
          end else if (run_rise) begin
            sm_nxt = FCW_SM_RUNNING;
            st_next.out.start = 1'b1;
          end
        end
        FCW_SM_RUNNING: begin
          if (!st_reg.cw[BIT_FB_CONTROL] || !fb_place) begin
            sm_nxt = FCW_SM_LOCKED;
          end else if (!run_bit) begin
            sm_nxt = FCW_SM_READY;
          end
        end
        default: begin
          sm_nxt = FCW_SM_LOCKED;
        end
      endcase
      st_next.out.run = (sm_nxt == FCW_SM_RUNNING);
    end else begin
      // direct use of the word, no sequencer
      sm_nxt = FCW_SM_LOCKED;
      if (!fb_place || !run_bit) begin
        st_next.out.run = 1'b0;
      end else if (run_rise) begin
        st_next.out.run = 1'b1;
        st_next.out.start = 1'b1;
      end
    end
    st_next.sm = 32'(sm_nxt);
    // precharge and main breaker handling
    st_next.out.breaker_open = 1'b0;
    st_next.out.precharge_abort = 1'b0;
    st_next.out.precharge_start = 1'b0;
    if (profile_sel_i != FCW_PROF_BASIC) begin
      if (!fb_place) begin
        // ordinary start command starts precharge
        st_next.out.precharge_start = drive_start_cmd_i;
      end else if (!st_reg.cw[BIT_PRECHARGE]) begin
        if (st_reg.brk_s2) begin
          st_next.out.breaker_open = 1'b1;
        end else begin
          st_next.out.precharge_abort = 1'b1;
        end
      end else begin
        st_next.out.precharge_start = precharge_en_i;
      end
    end
    // virtual inputs as selectable sources
    st_next.out.vin = vin_w;
    st_next.out.relay_output = vin_pick(vin_w, relay_src_sel_i);
    st_next.out.force_active = vin_pick(vin_w, force_src_sel_i);
    // identifier of the parameter that the force acts on
    st_next.force_id = force_id_i;
    // pin synchronisers
    st_next.btn_s1 = kp_start_btn_i;
    st_next.btn_s2 = st_reg.btn_s1;
    st_next.brk_s1 = breaker_closed_i;
    st_next.brk_s2 = st_reg.brk_s1;
    // control place write by parameter
    if (place_wr_i) begin
      st_next.place = fcw_place_e'(place_i);
    end
    // keypad start hold timer
    st_next.kp.copy = 1'b0;
    if (!st_reg.btn_s2) begin
      st_next.hold_cnt = '0;
      st_next.hold_done = 1'b0;
    end else if (!st_reg.hold_done) begin
      if (st_reg.hold_cnt == HOLD_LAST) begin
        // takeover wins over a parameter write in the same cycle
        st_next.hold_done = 1'b1;
        st_next.place = FCW_PLACE_KEYPAD;
        st_next.kp.copy = 1'b1;
        st_next.kp.run = st_reg.out.run;
        st_next.kp.dir = dir_i;
        st_next.kp.ref_val = ref_i;
      end else begin
        st_next.hold_cnt = st_reg.hold_cnt + HOLD_ONE;
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
      st_reg.cw <= CW_RST;
      st_reg.place <= PLACE_RST;
      st_reg.sm <= 32'(FCW_SM_LOCKED);
    end else begin
      st_reg <= st_next;
    end
  end

  // all outputs straight from flip-flops
  assign run_o = st_reg.out.run;
  assign start_o = st_reg.out.start;
  assign fault_ack_o = st_reg.out.fault_ack;
  assign breaker_open_o = st_reg.out.breaker_open;
  assign precharge_abort_o = st_reg.out.precharge_abort;
  assign precharge_start_o = st_reg.out.precharge_start;
  assign virtual_input_o = st_reg.out.vin;
  assign relay_output_o = st_reg.out.relay_output;
  assign force_active_o = st_reg.out.force_active;
  assign force_id_o = st_reg.force_id;
  assign place_o = st_reg.place;
  assign kp_copy_o = st_reg.kp.copy;
  assign kp_run_o = st_reg.kp.run;
  assign kp_dir_o = st_reg.kp.dir;
  assign kp_ref_o = st_reg.kp.ref_val;

endmodule

// ===== dv/fcw_master_model.sv
`timescale 1ns/1ps
// stand-in for the fieldbus master that writes control words
module fcw_master_model import fcw_pkg::*; (
  input wire logic mclk_i,
  output logic [CW_W-1:0] cw_o,
  output logic cw_valid_o
);
  // bus idle at start
  initial begin
    cw_o = CW_RST;
    cw_valid_o = 1'b0;
  end
  // one-cycle strobe, then one more cycle so the answer has landed
  task automatic send(input logic [CW_W-1:0] w);
    @(negedge mclk_i);
    cw_o = w;
    cw_valid_o = 1'b1;
    @(negedge mclk_i);
    cw_valid_o = 1'b0;
    // released bus shows the inverse, never the stale word
    cw_o = ~w;
    @(negedge mclk_i);
  endtask
endmodule

// ===== dv/fcw_decoder_assertions.sv
`timescale 1ns/1ps
// watches the decoder ports for timing of decoded commands
module fcw_decoder_assertions import fcw_pkg::*; (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [CW_W-1:0] cw_i,
  input wire logic cw_valid_i,
  input wire logic [1:0] profile_sel_i,
  input wire logic place_wr_i,
  input wire logic [1:0] place_i,
  input wire logic precharge_en_i,
  input wire logic drive_start_cmd_i,
  input wire logic run_o,
  input wire logic start_o,
  input wire logic fault_ack_o,
  input wire logic precharge_start_o,
  input wire logic [VIN_N-1:0] virtual_input_o,
  input wire logic [1:0] place_o,
  input wire logic kp_copy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  chk_start_on_edge: assert property (cw_valid_i && cw_i[BIT_RUN] &&
    profile_sel_i == 2'h1 && place_o == 2'h3 && !run_o && !$past(cw_valid_i)
    |-> ##2 start_o) else $error("start missing after run edge");
  chk_start_pulse: assert property (start_o |-> run_o ##1 !start_o)
    else $error("start not a single pulse with run");
  chk_run_stop: assert property (cw_valid_i && !cw_i[BIT_RUN] &&
    profile_sel_i == 2'h1 |-> ##2 !run_o) else $error("run stays after stop");
  chk_fault_pulse: assert property (fault_ack_o |->
    $past(cw_valid_i, 2) ##1 !fault_ack_o) else $error("fault ack bad pulse");
  chk_std_inputs: assert property ($past(cw_valid_i, 2) &&
    profile_sel_i == 2'h1 |-> virtual_input_o == {1'b0, $past(cw_i[14:11], 2)})
    else $error("standard virtual inputs wrong");
  chk_basic_inputs: assert property ($past(cw_valid_i, 2) &&
    profile_sel_i == 2'h0 |-> virtual_input_o == $past(cw_i[7:3], 2))
    else $error("basic virtual inputs wrong");
  chk_precharge_on: assert property ($past(cw_valid_i, 2) &&
    $past(cw_i[0], 2) && $past(precharge_en_i) &&
    $past(profile_sel_i) != 2'h0 && $past(place_o) == 2'h3 |->
    precharge_start_o) else $error("precharge not begun");
  chk_precharge_alt: assert property (place_o != 2'h3 &&
    $past(place_o) != 2'h3 && $past(profile_sel_i) != 2'h0 |->
    precharge_start_o == $past(drive_start_cmd_i))
    else $error("precharge not from start command");
  chk_place_write: assert property (place_wr_i |=>
    place_o == $past(place_i)) else $error("control place not written");
  chk_kp_takeover: assert property (kp_copy_o |->
    place_o == 2'h2 ##1 !kp_copy_o) else $error("keypad takeover wrong");
  cover property (start_o);
  cover property (fault_ack_o);
  cover property (kp_copy_o);
endmodule
bind fcw_decoder fcw_decoder_assertions CHK (
  .mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i),
  .cw_i(cw_i),
  .cw_valid_i(cw_valid_i),
  .profile_sel_i(profile_sel_i),
  .place_wr_i(place_wr_i),
  .place_i(place_i),
  .precharge_en_i(precharge_en_i),
  .drive_start_cmd_i(drive_start_cmd_i),
  .run_o(run_o),
  .start_o(start_o),
  .fault_ack_o(fault_ack_o),
  .precharge_start_o(precharge_start_o),
  .virtual_input_o(virtual_input_o),
  .place_o(place_o),
  .kp_copy_o(kp_copy_o)
);

// ===== dv/fcw_decoder_bench.sv
`timescale 1ns/1ps
// scenario bench for the control word decoder
module fieldbus_control_word_decoder_bench import fcw_pkg::*;;
  logic mclk_i, sys_rst_i, place_wr_i, precharge_en_i, drive_start_cmd_i;
  logic dir_i, breaker_closed_i, kp_start_btn_i;
  logic [1:0] profile_sel_i, place_i;
  logic [SEL_W-1:0] relay_src_sel_i, force_src_sel_i;
  logic [ID_W-1:0] force_id_i;
  logic [REF_W-1:0] ref_i;
  wire logic [CW_W-1:0] cw_i;
  wire logic cw_valid_i;
  logic run_o, start_o, fault_ack_o, breaker_open_o, precharge_abort_o;
  logic precharge_start_o, relay_output_o, force_active_o, kp_copy_o;
  logic kp_run_o, kp_dir_o;
  logic [VIN_N-1:0] virtual_input_o;
  logic [ID_W-1:0] force_id_o;
  logic [1:0] place_o;
  logic [REF_W-1:0] kp_ref_o;
  int bad_count = 0;
  int samples_checked = 0;
  // short hold so the takeover fits the run
  fcw_decoder #(.KP_HOLD_CYCLES(20)) DUT (.*);
  fcw_master_model MST (.mclk_i(mclk_i), .cw_o(cw_i), .cw_valid_o(cw_valid_i));
  always #2 mclk_i = ~mclk_i;
  // compare one value and count it
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // write the control place at a falling edge
  task automatic setp(logic [1:0] p);
    place_wr_i = 1'b1;
    place_i = p;
    @(negedge mclk_i);
    place_wr_i = 1'b0;
    chk("place", p, place_o);
  endtask
  // standard profile: run edge, stop, ignored bits, fault edge
  task automatic t_std;
    MST.send(16'h0008);
    chk("start", 1, start_o);
    @(negedge mclk_i);
    chk("start end", 0, start_o);
    MST.send(16'h0008);
    chk("start level", 0, start_o);
    MST.send(16'hAF76);
    chk("stop", 0, run_o);
    chk("vin", 5'h05, virtual_input_o);
    chk("ignored", 0, fault_ack_o | start_o);
    chk("relay", 1, relay_output_o);
    chk("force", 1, force_active_o);
    // other selectors: relay picks input 1, force an unused source
    relay_src_sel_i = 3'h1;
    force_src_sel_i = 3'h5;
    force_id_i = 16'h1C5E;
    @(negedge mclk_i);
    chk("relay sel", 0, relay_output_o);
    chk("force range", 0, force_active_o);
    chk("force id new", 16'h1C5E, force_id_o);
    MST.send(16'h0080);
    chk("fault", 1, fault_ack_o);
    MST.send(16'h0080);
    chk("fault level", 0, fault_ack_o);
    $display("standard test done");
  endtask
  // precharge and breaker by control place
  task automatic t_prech;
    setp(2'h1);
    drive_start_cmd_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk("alt precharge", 1, precharge_start_o);
    drive_start_cmd_i = 1'b0;
    setp(2'h3);
    // precharge bit alone is not enough without the enable
    precharge_en_i = 1'b0;
    MST.send(16'h0001);
    chk("precharge off", 0, precharge_start_o);
    precharge_en_i = 1'b1;
    @(negedge mclk_i);
    chk("precharge", 1, precharge_start_o);
    breaker_closed_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    MST.send(16'h0000);
    chk("breaker open", 1, breaker_open_o);
    breaker_closed_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    chk("abort", 1, precharge_abort_o);
    $display("precharge test done");
  endtask
  // basic profile bit layout
  task automatic t_basic;
    profile_sel_i = 2'h0;
    MST.send(16'h00F9);
    chk("basic run", 1, run_o);
    chk("basic vin", 5'h1F, virtual_input_o);
    MST.send(16'h0004);
    chk("basic fault", 1, fault_ack_o);
    $display("basic test done");
  endtask
  // sequencer profile gated by the control enable bit
  task automatic t_seq;
    // both sequencer profiles: enable, start, halt, restart, lock
    for (int p = 2; p < 4; p++) begin
      profile_sel_i = 2'(p);
      MST.send(16'h0400);
      MST.send(16'h1408);
      chk("seq start", 1, start_o);
      chk("seq vin", 5'h02, virtual_input_o);
      MST.send(16'h1400);
      chk("seq halt", 0, run_o);
      MST.send(16'h1408);
      chk("seq restart", 1, start_o);
      MST.send(16'h1008);
      chk("seq stop", 0, run_o);
    end
    $display("sequencer test done");
  endtask
  // keypad takeover after holding start
  task automatic t_kp;
    dir_i = 1'b0;
    ref_i = 16'h5A3C;
    kp_start_btn_i = 1'b1;
    for (int i = 0; i < 60 && kp_copy_o !== 1'b1; i++) @(negedge mclk_i);
    chk("kp copy", 1, kp_copy_o);
    chk("kp place", 2, place_o);
    chk("kp ref", 16'h5A3C, kp_ref_o);
    chk("kp dir", 0, kp_dir_o);
    chk("kp run", 0, kp_run_o);
    kp_start_btn_i = 1'b0;
    @(negedge mclk_i);
    chk("kp copy end", 0, kp_copy_o);
    $display("keypad test done");
  endtask
  // the single place where the run ends
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog far beyond the expected run length
  initial begin
    repeat (5000) @(posedge mclk_i);
    bad_count++;
    tally_and_finish;
  end
  // reset, then the scenarios in turn
  initial begin
    mclk_i = 1'b0;
    sys_rst_i = 1'b1;
    place_wr_i = 1'b0;
    place_i = 2'h0;
    drive_start_cmd_i = 1'b0;
    breaker_closed_i = 1'b0;
    kp_start_btn_i = 1'b0;
    precharge_en_i = 1'b1;
    dir_i = 1'b1;
    profile_sel_i = 2'h1;
    relay_src_sel_i = 3'h0;
    force_src_sel_i = 3'h2;
    force_id_i = 16'h00AB;
    ref_i = 16'h1234;
    repeat (8) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    chk("reset place", 3, place_o);
    @(negedge mclk_i);
    chk("force id", 16'h00AB, force_id_o);
    t_std;
    t_prech;
    t_basic;
    t_seq;
    t_kp;
    tally_and_finish;
  end
endmodule
